// ===== sseep_baud_div.sv
`timescale 1ns/100ps
// =====================================================================
// Baud divider: prescale by 1/8/32/2 then divide by (n+1)
module sseep_baud_div
    import sseep_pkg::*;
(
    input  wire logic       hclk,     // System clock
    input  wire logic       hresetn,  // Async reset, low
    input  wire logic [1:0] src_sel,  // Count source select
    input  wire logic [7:0] divisor,  // Divider value
    sseep_tick_if.src       tk        // Half-period tick out
);
    logic [4:0] pre_q;     // Prescaler count
    logic [7:0] cnt_q;     // Main divider count
    logic [4:0] pre_top;   // Prescaler limit
    logic       pre_tick;  // Prescaler output
    logic       tick_q;    // Registered tick
    assign pre_top  = (src_sel == 2'h0) ? 5'h00 : (src_sel == 2'h1) ? 5'h07 :
                      (src_sel == 2'h2) ? 5'h1F : 5'h01;
    assign pre_tick = (pre_q == pre_top);
    assign tk.tick  = tick_q;
    // =================================================================
    // Counters stop and reload while idle so the first half period is full
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q  <= 5'h00;
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
        end else if (!tk.run) begin
            pre_q  <= 5'h00;
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            pre_q  <= pre_tick ? 5'h00 : pre_q + 5'h01;
            tick_q <= pre_tick && (cnt_q == divisor);
            if (pre_tick) begin
                cnt_q <= (cnt_q == divisor) ? 8'h00 : cnt_q + 8'h01;
            end
        end
    end
endmodule

// ===== sseep_eeprom_model.sv
`timescale 1ns/100ps
// =====================================================================
// Serial memory far side: sends a reply byte, collects the command byte
module sseep_eeprom_model (
    input  wire logic       sclk,   // Transfer clock
    input  wire logic       cs_n,   // Select, active low
    input  wire logic       mosi,   // Data from the port
    input  wire logic [7:0] reply,  // Byte sent back
    output logic            miso,   // Data to the port
    output logic [7:0]      got     // Byte collected
);
    logic [7:0] sh;  // Reply shift register
    initial begin
        miso = 1'b1;
        sh = 8'h00;
        got = 8'h00;
    end
    // Load on select, first bit out at once
    always @(negedge cs_n) begin
        sh <= reply;
        miso <= reply[7];
    end
    // Released line flips so a stale level cannot pass for data
    always @(posedge cs_n) begin
        miso <= ~miso;
    end
    // Next bit on the falling edge, high bit first
    always @(negedge sclk) begin
        if (!cs_n) begin
            miso <= sh[7];
            sh <= {sh[6:0], 1'b0};
        end
    end
    // Capture on the rising edge, during the same clocks
    always @(posedge sclk) begin
        if (!cs_n) begin
            got <= {got[6:0], mosi};
        end
    end
endmodule

// ===== sseep_pkg.sv
// =====================================================================
// =====================================================================
package sseep_pkg;
    // =================================================================
    // Register byte addresses
    localparam logic [7:0] SSEEP_A_TXBUF  = 8'h00;  // Transmit buffer
    localparam logic [7:0] SSEEP_A_RXBUF  = 8'h04;  // Receive buffer, overrun flag
    localparam logic [7:0] SSEEP_A_BAUD   = 8'h08;  // baud_divider
    localparam logic [7:0] SSEEP_A_MODE   = 8'h0C;  // serial_mode_reg
    localparam logic [7:0] SSEEP_A_CTL0   = 8'h10;  // Clock and handshake control
    localparam logic [7:0] SSEEP_A_CTL1   = 8'h14;  // txrx_control_one
    localparam logic [7:0] SSEEP_A_SHARED = 8'h18;  // shared_serial_control
    localparam logic [7:0] SSEEP_A_SMR1   = 8'h1C;  // special_mode_one
    localparam logic [7:0] SSEEP_A_SMR2   = 8'h20;  // special_mode_two
    localparam logic [7:0] SSEEP_A_SMR3   = 8'h24;  // special_mode_three
    localparam logic [7:0] SSEEP_A_TXIC   = 8'h28;  // tx_interrupt_control
    // =================================================================
    // Field positions
    localparam int MODE_CLOCK_SOURCE_DIR  = 3;  // clock_source_dir
    localparam int MODE_PIN_POLARITY_SEL  = 7;  // pin_polarity_sel
    localparam int C0_CRS      = 2;  // handshake_sel
    localparam int C0_SHIFT_REG_EMPTY    = 3;  // shift_reg_empty
    localparam int C0_CRD      = 4;  // handshake_disable
    localparam int C0_CLOCK_POLARITY    = 6;  // clock_polarity
    localparam int C0_BIT_ORDER_SEL    = 7;  // bit_order_sel
    localparam int C1_TE       = 0;  // tx_enable
    localparam int C1_TI       = 1;  // tx_buffer_empty
    localparam int C1_RE       = 2;  // rx_enable
    localparam int C1_RI       = 3;  // rx_complete
    localparam int C1_IRS      = 4;  // tx_irq_cause_sel
    localparam int C1_RRM      = 5;  // continuous_rx_mode
    localparam int C1_LCH      = 6;  // data_invert_sel
    localparam int C1_ERE      = 7;  // error_output_enable
    localparam int IC_IR       = 3;  // irq_request_flag
    localparam int RX_OER      = 8;  // overrun_flag
    // =================================================================
    // Values and resets
    localparam logic [2:0] SSEEP_MODE_SYNC  = 3'h1;   // Clock synchronous mode
    localparam logic [2:0] SSEEP_LVL_OFF    = 3'h0;   // Interrupt level 0
    localparam logic [7:0] SSEEP_RST_BYTE   = 8'h00;  // Register reset value
    localparam logic [7:0] SSEEP_C0_RST     = 8'h08;  // Shift register empty set
    localparam logic [7:0] SSEEP_C1_WMASK   = 8'hF5;  // Writable control one bits
    localparam logic [7:0] SSEEP_SHR_RMASK  = 8'h4F;  // Defined shared bits
    localparam logic [7:0] SSEEP_SHR_JUNK   = 8'hB0;  // Value seen on reserved bits
    localparam int         SSEEP_BITS       = 8;      // Bits per transfer
endpackage

// ===== sseep_tick_if.sv
`timescale 1ns/100ps
// =====================================================================
// Shift clock enable between divider and shifter
interface sseep_tick_if;
    logic tick;  // One-cycle half-period pulse
    logic run;   // Divider allowed to count
    modport src (output tick, input run);
    modport dst (input tick, output run);
endinterface

// ===== sseep_top.sv
`timescale 1ns/100ps
// =====================================================================
// Clock synchronous serial channel for an external serial EEPROM
module sseep_top
    import sseep_pkg::*;
(
    input  wire logic        hclk,       // System clock
    input  wire logic        hresetn,    // Async reset, low
    input  wire logic        hsel,       // Slave select
    input  wire logic [31:0] haddr,      // Address
    input  wire logic [1:0]  htrans,     // Transfer type
    input  wire logic        hwrite,     // Write strobe
    input  wire logic [2:0]  hsize,      // Transfer size
    input  wire logic [31:0] hwdata,     // Write data
    input  wire logic        hready,     // Bus ready in
    output logic      [31:0] hrdata,     // Read data
    output logic             hreadyout,  // Always ready
    output logic             hresp,      // Always OKAY
    output logic             sclk_o,     // Transfer clock out
    output logic             txd_o,      // Serial data out
    input  wire logic        rxd_i,      // Serial data in
    output logic             tx_req_o    // Transmit request level
);
    // =================================================================
    // Registers
    logic [7:0] baud_q;           // baud_divider
    logic [7:0] mode_q;           // serial_mode_reg
    logic [7:0] ctl0_q;           // Clock control, writable part
    logic [7:0] ctl1_q;           // txrx_control_one, writable part
    logic [7:0] shr_q;            // shared_serial_control
    logic [7:0] smr1_q;           // special_mode_one
    logic [7:0] smr2_q;           // special_mode_two
    logic [7:0] smr3_q;           // special_mode_three
    logic [2:0] lvl_q;            // irq_priority_level
    logic       ir_q;             // irq_request_flag
    logic [7:0] txbuf_q;          // Transmit buffer
    logic       tbe_q;            // tx_buffer_empty
    logic [7:0] rxbuf_q;          // Receive buffer
    logic       ri_q;             // rx_complete
    logic       oer_q;            // overrun_flag
    logic [7:0] sh_q;             // Shift register
    logic [3:0] bit_q;            // Bits remaining
    logic       busy_q;           // Shift in progress
    logic       clk_q;            // Internal clock phase, idles at the inverse of cpol
    logic [1:0] rxs_q;            // rxd synchroniser
    logic       wr_q;             // Pending write data phase
    logic       rd_q;             // Pending read data phase
    logic [7:0] wa_q;             // Write address latch
    logic [31:0] hrdata_q;        // Read data register
    logic       txd_q;            // Output data register
    logic       sclk_q;           // Output clock register
    logic       req_q;            // Request output register
    logic       lead_q;           // Leading clock step seen last cycle
    sseep_tick_if tk ();          // Divider to shifter
    // =================================================================
    // Decode
    wire        acc    = hsel && hready && htrans[1];
    wire        sync_m = (mode_q[2:0] == SSEEP_MODE_SYNC) && !mode_q[MODE_CLOCK_SOURCE_DIR];
    wire        te     = ctl1_q[C1_TE];
    wire        re     = ctl1_q[C1_RE];
    wire        msbf   = ctl0_q[C0_BIT_ORDER_SEL];
    wire        inv    = ctl1_q[C1_LCH] ^ mode_q[MODE_PIN_POLARITY_SEL];
    wire        cpol   = ctl0_q[C0_CLOCK_POLARITY];
    wire        start  = sync_m && te && !tbe_q && !busy_q;
    wire        lead   = tk.tick && (clk_q ^ cpol);       // Drive edge reached
    wire        trail  = tk.tick && !(clk_q ^ cpol);      // Sample edge reached
    wire        rx_bit = rxs_q[1] ^ inv;
    wire        tx_bit = (msbf ? sh_q[7] : sh_q[0]) ^ inv;
    wire [7:0]  sh_nx  = msbf ? {sh_q[6:0], rx_bit} : {rx_bit, sh_q[7:1]};
    wire        last   = trail && (bit_q == 4'h1);
    wire        wr_go  = wr_q;
    wire        txb_wr = wr_go && (wa_q == SSEEP_A_TXBUF);
    wire        rxb_rd = acc && !hwrite && (haddr[7:0] == SSEEP_A_RXBUF);
    wire        cause  = ctl1_q[C1_IRS] ? last : (tbe_q == 1'b0 && start);
    // Handshake select and error output enable bits are stored only: flow control and
    // error output are never built, so both stay inert.
    wire [7:0]  c0_rd  = {ctl0_q[7:4], !busy_q, ctl0_q[2:0]};
    wire [7:0]  c1_rd  = {ctl1_q[7:4], ri_q, ctl1_q[2], tbe_q, ctl1_q[0]};
    wire [7:0]  shr_rd = (shr_q & SSEEP_SHR_RMASK) | SSEEP_SHR_JUNK;
    assign tk.run = busy_q;
    // =================================================================
    // Read mux
    logic [31:0] rd_mux;  // Selected read word
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            SSEEP_A_TXBUF:  rd_mux = {24'h000000, txbuf_q};
            SSEEP_A_RXBUF:  rd_mux = {23'h000000, oer_q, rxbuf_q};
            SSEEP_A_BAUD:   rd_mux = {24'h000000, baud_q};
            SSEEP_A_MODE:   rd_mux = {24'h000000, mode_q};
            SSEEP_A_CTL0:   rd_mux = {24'h000000, c0_rd};
            SSEEP_A_CTL1:   rd_mux = {24'h000000, c1_rd};
            SSEEP_A_SHARED: rd_mux = {24'h000000, shr_rd};
            SSEEP_A_SMR1:   rd_mux = {24'h000000, smr1_q};
            SSEEP_A_SMR2:   rd_mux = {24'h000000, smr2_q};
            SSEEP_A_SMR3:   rd_mux = {24'h000000, smr3_q};
            SSEEP_A_TXIC:   rd_mux = {28'h0000000, ir_q, lvl_q};
            default:        rd_mux = 32'h0000_0000;  // Unmapped reads zero
        endcase
    end
    // =================================================================
    // Bus phases; zero wait state so hreadyout stays high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            wa_q     <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wr_q <= acc && hwrite;
            rd_q <= acc && !hwrite;
            if (acc) begin
                wa_q <= haddr[7:0];
            end
            if (acc && !hwrite) begin
                hrdata_q <= rd_mux;
            end
        end
    end
    // =================================================================
    // Software registers; all reset to 00 except the empty flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            baud_q <= SSEEP_RST_BYTE;
            mode_q <= SSEEP_RST_BYTE;
            ctl0_q <= SSEEP_RST_BYTE;
            ctl1_q <= SSEEP_RST_BYTE;
            shr_q  <= SSEEP_RST_BYTE;
            smr1_q <= SSEEP_RST_BYTE;
            smr2_q <= SSEEP_RST_BYTE;
            smr3_q <= SSEEP_RST_BYTE;
            lvl_q  <= SSEEP_LVL_OFF;
        end else if (wr_go) begin
            unique case (wa_q)
                SSEEP_A_BAUD:   baud_q <= hwdata[7:0];
                SSEEP_A_MODE:   mode_q <= hwdata[7:0];
                SSEEP_A_CTL0:   ctl0_q <= hwdata[7:0] & 8'hF7;
                SSEEP_A_CTL1:   ctl1_q <= hwdata[7:0] & SSEEP_C1_WMASK;
                SSEEP_A_SHARED: shr_q  <= hwdata[7:0];
                SSEEP_A_SMR1:   smr1_q <= hwdata[7:0];
                SSEEP_A_SMR2:   smr2_q <= hwdata[7:0];
                SSEEP_A_SMR3:   smr3_q <= hwdata[7:0];
                SSEEP_A_TXIC:   lvl_q  <= hwdata[2:0];
                default:        ;  // Writes elsewhere are dropped
            endcase
        end
    end
    // =================================================================
    // Request flag: a new request wins over a software clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ir_q <= 1'b0;
        end else if (cause) begin
            ir_q <= 1'b1;
        end else if (wr_go && wa_q == SSEEP_A_TXIC && !hwdata[IC_IR]) begin
            ir_q <= 1'b0;
        end
    end
    // =================================================================
    // Transmit buffer and empty flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txbuf_q <= 8'h00;
            tbe_q   <= 1'b1;
        end else if (txb_wr) begin
            txbuf_q <= hwdata[7:0];
            tbe_q   <= 1'b0;
        end else if (start) begin
            tbe_q   <= 1'b1;
        end
    end
    // =================================================================
    // Shifter: eight clocks, drive on leading edge, sample on trailing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_q   <= 8'h00;
            bit_q  <= 4'h0;
            busy_q <= 1'b0;
            clk_q  <= 1'b1;
        end else if (start) begin
            sh_q   <= txbuf_q;
            bit_q  <= 4'(SSEEP_BITS);
            busy_q <= 1'b1;
            clk_q  <= !cpol;
        end else if (busy_q && tk.tick) begin
            clk_q <= !clk_q;
            if (trail) begin
                sh_q  <= sh_nx;
                bit_q <= bit_q - 4'h1;
            end
            if (last) begin
                busy_q <= 1'b0;
            end
        end else if (!busy_q) begin
            clk_q <= !cpol;
        end
    end
    // =================================================================
    // Receive buffer; a byte only arrives with a transmit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxbuf_q <= 8'h00;
            ri_q    <= 1'b0;
            oer_q   <= 1'b0;
        end else if (last && re) begin
            rxbuf_q <= sh_nx;
            ri_q    <= 1'b1;
            oer_q   <= oer_q | ri_q;
        end else if (rxb_rd) begin
            ri_q  <= 1'b0;
            oer_q <= 1'b0;
        end
    end
    // =================================================================
    // Pins: rxd crosses two flops; outputs registered.
    // Data moves one cycle after the leading step, together with the pin's
    // leading edge, so it never changes at the far side's sampling edge.
    // Limitation: the synchroniser delay needs half periods of 4+ cycles.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxs_q  <= 2'b11;
            txd_q  <= 1'b1;
            sclk_q <= 1'b1;
            req_q  <= 1'b0;
            lead_q <= 1'b0;
        end else begin
            rxs_q  <= {rxs_q[0], rxd_i};
            sclk_q <= clk_q;
            req_q  <= ir_q && (lvl_q != SSEEP_LVL_OFF);
            lead_q <= lead && busy_q;
            if (lead_q) begin
                txd_q <= tx_bit;
            end else if (!busy_q && (sclk_q == clk_q)) begin
                txd_q <= 1'b1;    // Idle only after the last sampling edge is out
            end
        end
    end
    assign hrdata    = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign sclk_o    = sclk_q;
    assign txd_o     = txd_q;
    assign tx_req_o  = req_q;
    // =================================================================
    // Divider
    sseep_baud_div u_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .src_sel (ctl0_q[1:0]),
        .divisor (baud_q),
        .tk      (tk)
    );
    // =================================================================
    // Checks
    property p_busy_len;
        @(posedge hclk) disable iff (!hresetn)
        start |=> busy_q [*8];
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("shift ended early");
    property p_tbe_set;
        @(posedge hclk) disable iff (!hresetn)
        start |=> tbe_q;
    endproperty
    a_tbe_set: assert property (p_tbe_set) else $error("buffer not freed");
    property p_no_tx;
        @(posedge hclk) disable iff (!hresetn)
        (!te && !busy_q) |=> !busy_q;
    endproperty
    a_no_tx: assert property (p_no_tx) else $error("sent while disabled");
    property p_ri;
        @(posedge hclk) disable iff (!hresetn)
        (last && re) |=> ri_q;
    endproperty
    a_ri: assert property (p_ri) else $error("receive flag missing");
    property p_no_rx;
        @(posedge hclk) disable iff (!hresetn)
        (!re && !rxb_rd) |=> !$rose(ri_q);
    endproperty
    a_no_rx: assert property (p_no_rx) else $error("received while disabled");
    property p_ir;
        @(posedge hclk) disable iff (!hresetn)
        cause |=> ir_q;
    endproperty
    a_ir: assert property (p_ir) else $error("request lost");
    property p_req_off;
        @(posedge hclk) disable iff (!hresetn)
        (lvl_q == SSEEP_LVL_OFF) |=> !tx_req_o;
    endproperty
    a_req_off: assert property (p_req_off) else $error("level 0 request");
    property p_empty;
        @(posedge hclk) disable iff (!hresetn)
        $fell(busy_q) |-> (bit_q == 4'h0);
    endproperty
    a_empty: assert property (p_empty) else $error("shift empty wrong");
    property p_tx_fall;
        @(posedge hclk) disable iff (!hresetn)
        ($changed(txd_q) && $past(busy_q)) |-> (sclk_q == cpol);
    endproperty
    a_tx_fall: assert property (p_tx_fall) else $error("data moved off leading edge");
endmodule

// ===== sync_serial_eeprom_port_bench.sv
`timescale 1ns/100ps
// =====================================================================
// Bench: bus tasks, three framed transfers against the memory model
module sync_serial_eeprom_port_bench;
    import sseep_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, cs_n;  // Clock, reset, select
    logic [31:0] haddr, hwdata, hrdata, rd;          // Bus words
    logic [1:0]  htrans;                             // Transfer type
    logic [2:0]  hsize;                              // Transfer size
    logic        hreadyout, hresp, sclk, txd, rxd;   // Handshake and pins
    logic        tx_req;                             // Request level
    logic [7:0]  reply, got;                         // Model bytes
    int          n_fail, check_count, n_fall, i;     // Counters
    sseep_top i_sseep_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sclk_o(sclk), .txd_o(txd), .rxd_i(rxd), .tx_req_o(tx_req));
    sseep_eeprom_model i_sseep_eeprom_model (.sclk(sclk), .cs_n(cs_n), .mosi(txd),
        .reply(reply), .miso(rxd), .got(got));
    // =================================================================
    // Clock and framed edge count
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    always @(negedge sclk) begin
        if (!cs_n) n_fall++;
    end
    // =================================================================
    // Tasks
    task chk(input logic [31:0] v, input logic [31:0] exp);
        check_count++;
        if (v !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, v, exp);
        end
    endtask
    // One single transfer; waits for ready at both phases
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd & m, exp);
    endtask
    // Poll one bit until set; gives up after 400 reads and the check fails
    task poll(input logic [7:0] a, input int b);
        for (int k = 0; k < 400; k++) begin
            bus(1'b0, a, 32'h0);
            if (rd[b] === 1'b1) break;
        end
        chk({31'h0, rd[b]}, 32'h1);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Watchdog: the whole run needs well under a tenth of this
    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        complete_run();
    end
    // =================================================================
    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwdata = 32'h0;
        hsize = 3'b010;
        cs_n = 1'b1;
        reply = 8'hA5;
        n_fail = 0;
        check_count = 0;
        n_fall = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        chk({30'h0, sclk, txd}, 32'h3);
        for (i = 0; i < 3; i++) begin
            rdc(SSEEP_A_SMR1 + 8'(i * 4), 32'hFF, 32'h0);
        end
        rdc(SSEEP_A_CTL1, 32'hFF, 32'h02);
        chk({31'h0, hresp}, 32'h0);                              // Always OKAY
        bus(1'b1, SSEEP_A_SMR3, 32'h0);
        bus(1'b1, SSEEP_A_CTL0, 32'h0);
        rdc(SSEEP_A_CTL0, 32'h08, 32'h08);
        bus(1'b1, SSEEP_A_SHARED, 32'h0);
        rdc(SSEEP_A_SHARED, 32'hB0, {24'h0, SSEEP_SHR_JUNK});
        bus(1'b1, SSEEP_A_BAUD, 32'h03);
        rdc(SSEEP_A_BAUD, 32'hFF, 32'h03);
        bus(1'b1, SSEEP_A_CTL0, 32'h90);
        bus(1'b1, SSEEP_A_CTL1, 32'h05);
        cs_n <= 1'b0;
        bus(1'b1, SSEEP_A_TXBUF, 32'h3C);
        repeat (80) @(posedge hclk);
        chk(32'(n_fall), 32'h0);
        bus(1'b1, SSEEP_A_CTL1, 32'h04);
        bus(1'b1, SSEEP_A_MODE, 32'h01);
        repeat (80) @(posedge hclk);
        chk(32'(n_fall), 32'h0);
        bus(1'b1, SSEEP_A_CTL1, 32'h05);
        poll(SSEEP_A_TXIC, IC_IR);
        chk({31'h0, tx_req}, 32'h0);
        bus(1'b1, SSEEP_A_TXIC, 32'h0);
        rdc(SSEEP_A_TXIC, 32'h08, 32'h0);
        poll(SSEEP_A_CTL1, C1_RI);
        rdc(SSEEP_A_CTL0, 32'h08, 32'h08);
        chk(32'(n_fall), 32'h8);
        chk({24'h0, got}, 32'h3C);
        rdc(SSEEP_A_RXBUF, 32'hFF, 32'hA5);
        rdc(SSEEP_A_CTL1, 32'h08, 32'h0);
        // Second frame with a live priority level drives the request pin
        cs_n <= 1'b1;
        reply <= 8'h5A;
        bus(1'b1, SSEEP_A_TXIC, 32'h01);
        cs_n <= 1'b0;
        bus(1'b1, SSEEP_A_TXBUF, 32'hC3);
        for (i = 0; i < 400 && tx_req !== 1'b1; i++) @(posedge hclk);
        chk({31'h0, tx_req}, 32'h1);
        poll(SSEEP_A_CTL1, C1_RI);
        rdc(SSEEP_A_RXBUF, 32'hFF, 32'h5A);
        chk({24'h0, got}, 32'hC3);
        bus(1'b1, SSEEP_A_TXIC, 32'h0);
        repeat (2) @(posedge hclk);
        chk({31'h0, tx_req}, 32'h0);
        cs_n <= 1'b1;
        chk({30'h0, sclk, txd}, 32'h3);
        // Third frame: slower source, data inverted, request at frame end
        reply <= 8'h0F;
        bus(1'b1, SSEEP_A_BAUD, 32'h00);
        bus(1'b1, SSEEP_A_CTL0, 32'h91);
        bus(1'b1, SSEEP_A_CTL1, 32'h55);
        cs_n <= 1'b0;
        bus(1'b1, SSEEP_A_TXBUF, 32'h96);
        repeat (2) @(posedge hclk);
        rdc(SSEEP_A_CTL0, 32'h08, 32'h0);
        rdc(SSEEP_A_TXIC, 32'h08, 32'h0);
        poll(SSEEP_A_CTL1, C1_RI);
        rdc(SSEEP_A_TXIC, 32'h08, 32'h08);
        rdc(SSEEP_A_RXBUF, 32'hFF, 32'hF0);
        chk({24'h0, got}, 32'h69);
        bus(1'b1, SSEEP_A_TXIC, 32'h0);
        cs_n <= 1'b1;
        complete_run();
    end
endmodule
